// *** nta_pkg.sv ***
// constants shared by both ends of the tag access link
`default_nettype none
package nta_pkg;
  // reader frame opcodes
  localparam logic [7:0] OP_REQA = 8'h26;
  localparam logic [7:0] OP_WUPA = 8'h52;
  localparam logic [7:0] OP_SEL_CL1 = 8'h93;
  localparam logic [7:0] OP_SEL_CL2 = 8'h95;
  localparam logic [7:0] NVB_ANTICOL = 8'h20;
  localparam logic [7:0] NVB_SELECT = 8'h70;
  localparam logic [7:0] OP_READ = 8'h30;
  localparam logic [7:0] OP_WRITE = 8'ha2;
  localparam logic [7:0] OP_PWD_AUTH = 8'h1b;
  // tag answers
  localparam logic [15:0] ATQA = 16'h0044;
  localparam logic [7:0] CASCADE_TAG = 8'h88;
  localparam logic [7:0] SAK_CL1 = 8'h04;
  localparam logic [7:0] SAK_CL2 = 8'h00;
  localparam logic [7:0] ACK = 8'h0a;
  localparam logic [7:0] NAK = 8'h00;
  // memory map
  localparam logic [7:0] FIRST_PROT_PAGE = 8'h0e;
  localparam logic [7:0] PWD_PAGE = 8'he5;
  localparam int READ_PAGES = 4;
  localparam int RX_MAX = 8;
  // reader register offsets
  localparam logic [3:0] REG_OP = 4'h0;
  localparam logic [3:0] REG_PAGE = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_PWD = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA0 = 4'h8;
  // reader operations written to REG_OP
  localparam logic [2:0] RQ_WAKE = 3'h0;
  localparam logic [2:0] RQ_ANTICOL1 = 3'h1;
  localparam logic [2:0] RQ_SELECT1 = 3'h2;
  localparam logic [2:0] RQ_ANTICOL2 = 3'h3;
  localparam logic [2:0] RQ_SELECT2 = 3'h4;
  localparam logic [2:0] RQ_READ = 3'h5;
  localparam logic [2:0] RQ_WRITE = 3'h6;
  localparam logic [2:0] RQ_AUTH = 3'h7;
  // tag states
  typedef enum logic [2:0] {
    st_idle, st_ready1, st_ready2, st_active, st_unlocked_protected_state
  } nta_state_t;
endpackage
`default_nettype wire

// *** nta_link_if.sv ***
// byte link between the reader end and the tag end
`default_nettype none
interface nta_link_if;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rd_last;
  logic tg_valid;
  logic [7:0] tg_data;
  logic tg_last;
  modport tag (input rd_valid, rd_data, rd_last,
               output tg_valid, tg_data, tg_last);
  modport reader (output rd_valid, rd_data, rd_last,
                  input tg_valid, tg_data, tg_last);
endinterface
`default_nettype wire

// *** nta_tag.sv ***
// tag end: command state machine guarding the configuration memory
`default_nettype none
// How it works
// R1 - reset puts the tag in idle
// R2 - only REQA or WUPA leaves idle
// R3 - idle silently drops every other frame
// R4 - level 1 resolves first three UID bytes
// R5 - matching level 1 SELECT enters ready2
// R6 - level 2 resolves last four UID bytes
// R7 - matching level 2 SELECT enters active
// R8 - active allows unprotected reads and writes
// R9 - right password moves to unlocked state
// R10 - protected pages need successful password check
// R11 - good password answered with PACK
// R12 - READ returns four pages, sixteen bytes
// R13 - WRITE stores four bytes to page
// R14 - unlocked write to 0xE5 sets password
// R15 - page 0xE5 always reads as zero
// R16 - page bytes sent little endian
// R17 - locked protected access gets NAK, no change
// R18 - bad password: NAK, locked, back idle
module nta_tag #(
  parameter logic [55:0] UID = 56'h06_05_04_03_02_01_00,
  parameter int PAGES = 230,
  parameter logic [31:0] PWD_RESET = 32'h0000e215,
  parameter logic [15:0] PACK = 16'h0000
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // link to the reader
  nta_link_if.tag link,
  // local read port into configuration memory
  input wire logic [7:0] cfg_page_i,
  output logic [31:0] cfg_data_o,
  // status
  output logic [2:0] state_o,
  output logic unlocked_o
);
  // ----------------------------------------------------------------
  // frame reception
  // ----------------------------------------------------------------
  logic [7:0] rx_r [nta_pkg::RX_MAX];
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_len_r;
  logic frame_r;
  logic tx_busy_r;
  logic rx_take;

  // reader bytes arriving while an answer is out are dropped one by one
  assign rx_take = link.rd_valid && !tx_busy_r;

  // collect bytes; extra bytes past the buffer only bump the count
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_cnt_r <= 4'h0;
      rx_len_r <= 4'h0;
      frame_r <= 1'b0;
      for (int i = 0; i < nta_pkg::RX_MAX; i++) rx_r[i] <= 8'h00;
    end else begin
      frame_r <= rx_take && link.rd_last;
      if (rx_take) begin
        if (rx_cnt_r < 4'(nta_pkg::RX_MAX))
          rx_r[rx_cnt_r[2:0]] <= link.rd_data;
        if (link.rd_last) begin
          rx_cnt_r <= 4'h0;
          rx_len_r <= (rx_cnt_r == 4'hf) ? 4'hf : rx_cnt_r + 4'h1;
        end else if (rx_cnt_r != 4'hf) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // memory and password
  // ----------------------------------------------------------------
  logic [31:0] mem_r [PAGES];
  logic [31:0] pwd_r;
  logic wr_en;
  logic pwd_wr;
  logic [7:0] wr_page;
  logic [31:0] wr_data;

  // a write of the password page never lands in memory [R14]
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < PAGES; i++) mem_r[i] <= 32'h0000_0000;
    end else if (wr_en) begin
      mem_r[wr_page] <= wr_data; // [R13]
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) pwd_r <= PWD_RESET;
    else if (pwd_wr) pwd_r <= wr_data; // [R14]
  end

  // page value as seen from the link; password page hidden
  function automatic logic [31:0] page_val(input logic [7:0] p);
    if (p == nta_pkg::PWD_PAGE || int'(p) >= PAGES)
      page_val = 32'h0000_0000; // [R15]
    else
      page_val = mem_r[p];
  endfunction

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cfg_data_o <= 32'h0000_0000;
    else cfg_data_o <= page_val(cfg_page_i);
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  nta_pkg::nta_state_t state_r;
  nta_pkg::nta_state_t state_nxt;
  logic [127:0] rsp_nxt;
  logic [4:0] rsp_len_nxt;
  logic [31:0] cl1_part;
  logic [31:0] cl2_part;
  logic [31:0] rx_word;
  logic [7:0] op;
  logic unlocked;
  logic prot_hit;
  logic [31:0] part;
  logic [7:0] sel;

  assign cl1_part = {UID[23:0], nta_pkg::CASCADE_TAG}; // [R4]
  assign cl2_part = UID[55:24]; // [R6]
  assign op = rx_r[0];
  // the level being resolved picks the UID half and the select opcode
  assign part = (state_r == nta_pkg::st_ready1) ? cl1_part : cl2_part;
  assign sel = (state_r == nta_pkg::st_ready1) ?
               nta_pkg::OP_SEL_CL1 : nta_pkg::OP_SEL_CL2;
  assign unlocked = state_r == nta_pkg::st_unlocked_protected_state;
  // bytes 2..5 of select and write frames, first byte lowest [R16]
  assign rx_word = {rx_r[5], rx_r[4], rx_r[3], rx_r[2]};

  function automatic logic [7:0] bcc(input logic [31:0] w);
    bcc = w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
  endfunction

  // one decision per received frame
  always_comb begin
    state_nxt = state_r;
    rsp_nxt = 128'h0;
    rsp_len_nxt = 5'd0;
    wr_en = 1'b0;
    pwd_wr = 1'b0;
    wr_page = rx_r[1];
    wr_data = rx_word;
    prot_hit = 1'b0;
    if (frame_r) begin
      case (state_r)
        nta_pkg::st_idle: begin
          if (rx_len_r == 4'd1 &&
              (op == nta_pkg::OP_REQA || op == nta_pkg::OP_WUPA)) begin
            state_nxt = nta_pkg::st_ready1; // [R2]
            rsp_nxt[15:0] = nta_pkg::ATQA;
            rsp_len_nxt = 5'd2;
          end // anything else: no answer, stay idle [R3]
        end
        nta_pkg::st_ready1, nta_pkg::st_ready2: begin
          if (rx_len_r == 4'd2 && op == sel &&
              rx_r[1] == nta_pkg::NVB_ANTICOL) begin
            rsp_nxt[39:0] = {bcc(part), part}; // [R4] [R6]
            rsp_len_nxt = 5'd5;
          end else if (rx_len_r == 4'd7 && op == sel &&
                       rx_r[1] == nta_pkg::NVB_SELECT &&
                       rx_word == part && rx_r[6] == bcc(part)) begin
            rsp_len_nxt = 5'd1;
            if (state_r == nta_pkg::st_ready1) begin
              state_nxt = nta_pkg::st_ready2; // [R5]
              rsp_nxt[7:0] = nta_pkg::SAK_CL1;
            end else begin
              state_nxt = nta_pkg::st_active; // [R7]
              rsp_nxt[7:0] = nta_pkg::SAK_CL2;
            end
          end else begin
            state_nxt = nta_pkg::st_idle;
          end
        end
        nta_pkg::st_active, nta_pkg::st_unlocked_protected_state: begin
          rsp_len_nxt = 5'd1;
          rsp_nxt[7:0] = nta_pkg::NAK;
          if (rx_len_r == 4'd2 && op == nta_pkg::OP_READ) begin
            // any of the four pages protected blocks the whole read
            prot_hit = (rx_r[1] + 8'd3 >= nta_pkg::FIRST_PROT_PAGE) ||
                       (rx_r[1] > 8'hfc);
            if (!prot_hit || unlocked) begin // [R8] [R10] [R17]
              for (int i = 0; i < nta_pkg::READ_PAGES; i++)
                rsp_nxt[i*32 +: 32] = page_val(rx_r[1] + 8'(i)); // [R12]
              rsp_len_nxt = 5'd16;
            end
          end else if (rx_len_r == 4'd6 && op == nta_pkg::OP_WRITE) begin
            prot_hit = rx_r[1] >= nta_pkg::FIRST_PROT_PAGE;
            if (unlocked && rx_r[1] == nta_pkg::PWD_PAGE) begin
              pwd_wr = 1'b1; // [R14]
              rsp_nxt[7:0] = nta_pkg::ACK;
            end else if ((!prot_hit || unlocked) &&
                         int'(rx_r[1]) < PAGES &&
                         rx_r[1] != nta_pkg::PWD_PAGE) begin
              wr_en = 1'b1; // [R8] [R13] [R17]
              rsp_nxt[7:0] = nta_pkg::ACK;
            end
          end else if (rx_len_r == 4'd5 &&
                       op == nta_pkg::OP_PWD_AUTH) begin
            wr_data = {rx_r[4], rx_r[3], rx_r[2], rx_r[1]};
            if (wr_data == pwd_r) begin
              state_nxt = nta_pkg::st_unlocked_protected_state; // [R9]
              rsp_nxt[15:0] = PACK; // [R11]
              rsp_len_nxt = 5'd2;
            end else begin
              state_nxt = nta_pkg::st_idle; // [R18]
            end
          end else begin
            rsp_len_nxt = 5'd0; // unknown frame: no answer
          end
        end
        default: state_nxt = nta_pkg::st_idle;
      endcase
    end
  end

  // state register; reset is the power-up in the field
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) state_r <= nta_pkg::st_idle; // [R1]
    else state_r <= state_nxt;
  end

  assign state_o = state_r;
  assign unlocked_o = unlocked;

  // ----------------------------------------------------------------
  // answer transmission, one byte a cycle, lowest byte first
  // ----------------------------------------------------------------
  logic [127:0] tx_r;
  logic [4:0] tx_left_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_r <= 128'h0;
      tx_left_r <= 5'd0;
      tx_busy_r <= 1'b0;
    end else if (rsp_len_nxt != 5'd0) begin
      tx_r <= rsp_nxt;
      tx_left_r <= rsp_len_nxt;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r) begin
      tx_r <= {8'h00, tx_r[127:8]}; // [R16]
      tx_left_r <= tx_left_r - 5'd1;
      tx_busy_r <= tx_left_r != 5'd1;
    end
  end

  assign link.tg_valid = tx_busy_r;
  assign link.tg_data = tx_r[7:0];
  assign link.tg_last = tx_busy_r && tx_left_r == 5'd1;
endmodule
`default_nettype wire

// *** nta_reader.sv ***
// reader end: register-driven frame builder and answer collector
`default_nettype none
module nta_reader #(
  parameter int WAIT_CYCLES = 64
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // link to the tag
  nta_link_if.reader link
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {h_idle, h_send, h_wait} nta_host_t;
  nta_host_t hs_r;
  logic [2:0] op_r;
  logic [7:0] page_r;
  logic [31:0] wdata_r;
  logic [31:0] pwd_r;
  logic [127:0] ans_r;
  logic [4:0] ans_cnt_r;
  logic ok_r;
  logic [39:0] part_r;
  logic start;

  // a new order while busy is ignored
  assign start = reg_wr_i && reg_addr_i == nta_pkg::REG_OP &&
                 hs_r == h_idle;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_r <= 3'h0;
      page_r <= 8'h00;
      wdata_r <= 32'h0;
      pwd_r <= 32'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        nta_pkg::REG_OP: if (start) op_r <= reg_wdata_i[2:0];
        nta_pkg::REG_PAGE: page_r <= reg_wdata_i[7:0];
        nta_pkg::REG_WDATA: wdata_r <= reg_wdata_i;
        nta_pkg::REG_PWD: pwd_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        nta_pkg::REG_OP: reg_rdata_o <= {29'h0, op_r};
        nta_pkg::REG_PAGE: reg_rdata_o <= {24'h0, page_r};
        nta_pkg::REG_WDATA: reg_rdata_o <= wdata_r;
        nta_pkg::REG_STATUS:
          reg_rdata_o <= {24'h0, ans_cnt_r, ok_r, 1'b0, hs_r != h_idle};
        4'h8, 4'h9, 4'ha, 4'hb:
          reg_rdata_o <= ans_r[reg_addr_i[1:0]*32 +: 32];
        default: reg_rdata_o <= 32'h0; // password is write only
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // frame builder
  // ----------------------------------------------------------------
  logic [55:0] frm;
  logic [2:0] frm_len;
  logic [7:0] sel;

  always_comb begin
    sel = (op_r == nta_pkg::RQ_ANTICOL1 || op_r == nta_pkg::RQ_SELECT1) ?
          nta_pkg::OP_SEL_CL1 : nta_pkg::OP_SEL_CL2;
    frm = 56'h0;
    frm_len = 3'd1;
    case (op_r)
      nta_pkg::RQ_WAKE: frm[7:0] = nta_pkg::OP_WUPA;
      nta_pkg::RQ_ANTICOL1, nta_pkg::RQ_ANTICOL2: begin
        frm[15:0] = {nta_pkg::NVB_ANTICOL, sel};
        frm_len = 3'd2;
      end
      nta_pkg::RQ_SELECT1, nta_pkg::RQ_SELECT2: begin
        frm = {part_r, nta_pkg::NVB_SELECT, sel};
        frm_len = 3'd7;
      end
      nta_pkg::RQ_READ: begin
        frm[15:0] = {page_r, nta_pkg::OP_READ};
        frm_len = 3'd2;
      end
      nta_pkg::RQ_WRITE: begin
        frm[47:0] = {wdata_r, page_r, nta_pkg::OP_WRITE};
        frm_len = 3'd6;
      end
      nta_pkg::RQ_AUTH: begin
        frm[39:0] = {pwd_r, nta_pkg::OP_PWD_AUTH};
        frm_len = 3'd5;
      end
      default: frm_len = 3'd1;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer: send, then wait a bounded time for the answer
  // ----------------------------------------------------------------
  logic [2:0] idx_r;
  logic [$clog2(WAIT_CYCLES+1)-1:0] wait_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_r <= h_idle;
      idx_r <= 3'd0;
      wait_r <= '0;
      ans_r <= 128'h0;
      ans_cnt_r <= 5'd0;
      ok_r <= 1'b0;
      part_r <= 40'h0;
    end else begin
      case (hs_r)
        h_idle: if (start) begin
          hs_r <= h_send;
          idx_r <= 3'd0;
          ans_r <= 128'h0;
          ans_cnt_r <= 5'd0;
          ok_r <= 1'b0;
        end
        h_send: begin
          idx_r <= idx_r + 3'd1;
          if (idx_r == frm_len - 3'd1) begin
            hs_r <= h_wait;
            wait_r <= '0;
          end
        end
        h_wait: begin
          wait_r <= wait_r + 1'b1;
          if (link.tg_valid) begin
            if (ans_cnt_r < 5'd16)
              ans_r[ans_cnt_r[3:0]*8 +: 8] <= link.tg_data;
            ans_cnt_r <= ans_cnt_r + 5'd1;
          end
          if (link.tg_valid && link.tg_last) begin
            hs_r <= h_idle;
            ok_r <= !(ans_cnt_r == 5'd0 && link.tg_data == nta_pkg::NAK);
            if (ans_cnt_r == 5'd4)
              part_r <= {link.tg_data, ans_r[31:0]};
          end else if (!link.tg_valid && ans_cnt_r == 5'd0 &&
                       wait_r == WAIT_CYCLES[$bits(wait_r)-1:0]) begin
            hs_r <= h_idle; // silence: ok stays low
          end
        end
        default: hs_r <= h_idle;
      endcase
    end
  end

  assign link.rd_valid = hs_r == h_send;
  assign link.rd_data = frm[idx_r*8 +: 8];
  assign link.rd_last = hs_r == h_send && idx_r == frm_len - 3'd1;
endmodule
`default_nettype wire

// *** nta_link_checker.sv ***
// assertions on the byte link between the reader and tag ends
`default_nettype none
module nta_link_checker #(
  parameter logic [15:0] PACK = 16'h0000
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // reader to tag
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_last,
  // tag to reader
  input wire logic tg_valid,
  input wire logic [7:0] tg_data,
  input wire logic tg_last
);
  logic [2:0] ri_r;
  logic [7:0] op_r;
  logic [7:0] sec_r;
  logic [4:0] tc_r;
  logic wake_w;
  logic sel_w;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // --------------------------------------------------------------
  // request tracking
  // --------------------------------------------------------------
  // byte position in the reader frame
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ri_r <= 3'h0;
    else if (rd_valid) ri_r <= rd_last ? 3'h0 : ri_r + 3'h1;
  end
  // opcode held until the next frame, answers come after it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) op_r <= 8'h00;
    else if (rd_valid && ri_r == 3'h0) op_r <= rd_data;
  end
  // second byte tells anticollision from select
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sec_r <= 8'h00;
    else if (rd_valid && ri_r == 3'h1) sec_r <= rd_data;
  end
  // answer bytes seen before the current one
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) tc_r <= 5'h00;
    else if (tg_valid) tc_r <= tg_last ? 5'h00 : tc_r + 5'h01;
  end
  assign wake_w = op_r == nta_pkg::OP_REQA || op_r == nta_pkg::OP_WUPA;
  assign sel_w = op_r == nta_pkg::OP_SEL_CL1 || op_r == nta_pkg::OP_SEL_CL2;
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  sequence s_atqa;
    tg_data == nta_pkg::ATQA[7:0] && !tg_last
    ##1 tg_data == nta_pkg::ATQA[15:8] && tg_last;
  endsequence
  sequence s_pack;
    tg_data == PACK[7:0] && !tg_last ##1 tg_data == PACK[15:8] && tg_last;
  endsequence
  chk_answer_delay: assert property ($rose(tg_valid) |->
    $past(rd_last, 2)) else $error("answer start late");
  chk_answer_run: assert property (tg_valid && !tg_last |=> tg_valid)
    else $error("answer bytes not contiguous");
  chk_wake_atqa: assert property ($rose(tg_valid) && wake_w |-> s_atqa)
    else $error("wake answer wrong");
  chk_anticol_len: assert property (tg_last && sel_w &&
    sec_r == nta_pkg::NVB_ANTICOL |-> tc_r == 5'd4)
    else $error("anticollision answer length wrong");
  chk_sel1_sak: assert property (
    tg_last && sec_r == nta_pkg::NVB_SELECT && op_r == nta_pkg::OP_SEL_CL1
    |-> tc_r == 5'd0 && tg_data == nta_pkg::SAK_CL1)
    else $error("level one select answer wrong");
  chk_sel2_sak: assert property (
    tg_last && sec_r == nta_pkg::NVB_SELECT && op_r == nta_pkg::OP_SEL_CL2
    |-> tc_r == 5'd0 && tg_data == nta_pkg::SAK_CL2)
    else $error("level two select answer wrong");
  chk_read_len: assert property (
    tg_last && op_r == nta_pkg::OP_READ |->
    tc_r == 5'd15 || (tc_r == 5'd0 && tg_data == nta_pkg::NAK))
    else $error("read answer length wrong");
  chk_write_ack: assert property (
    tg_last && op_r == nta_pkg::OP_WRITE |->
    tc_r == 5'd0 && (tg_data == nta_pkg::ACK || tg_data == nta_pkg::NAK))
    else $error("write answer wrong");
  chk_auth_pack: assert property ($rose(tg_valid) && !tg_last &&
    op_r == nta_pkg::OP_PWD_AUTH |-> s_pack) else $error("pack wrong");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the reader and tag ends joined by the link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [55:0] UID = 56'h06_05_04_03_02_01_00;
  localparam logic [31:0] PW0 = 32'h0000e215;
  localparam logic [31:0] PW1 = 32'h78563412;
  localparam logic [31:0] PD = 32'hcafef00d;
  localparam logic [15:0] PK = 16'h5aa5;
  logic ref_clk_i;
  logic reset_n_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [7:0] cfg_page_i;
  logic [31:0] cfg_data_o;
  logic [2:0] state_o;
  logic unlocked_o;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
  // --------------------------------------------------------------
  // both ends and the checker
  // --------------------------------------------------------------
  nta_link_if nta_link_if_inst ();
  nta_tag #(.UID(UID), .PWD_RESET(PW0), .PACK(PK)) nta_tag_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(nta_link_if_inst),
    .cfg_page_i(cfg_page_i), .cfg_data_o(cfg_data_o), .state_o(state_o),
    .unlocked_o(unlocked_o));
  // short silence timeout keeps refused frames cheap
  nta_reader #(.WAIT_CYCLES(16)) nta_reader_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .link(nta_link_if_inst));
  nta_link_checker #(.PACK(PK)) nta_link_checker_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .rd_valid(nta_link_if_inst.rd_valid), .rd_data(nta_link_if_inst.rd_data),
    .rd_last(nta_link_if_inst.rd_last), .tg_valid(nta_link_if_inst.tg_valid),
    .tg_data(nta_link_if_inst.tg_data), .tg_last(nta_link_if_inst.tg_last));
  // clock at 200 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // hang guard, a full run needs well under a tenth of this
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // register port and helpers
  // --------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // start an operation, poll busy, judge ok flag and answer length
  task automatic op(input logic [2:0] c, input logic ok, input logic [4:0] n);
    logic [31:0] s;
    wr(nta_pkg::REG_OP, {29'h0, c});
    s = 32'h1;
    for (int i = 0; i < 100 && s[0] !== 1'b0; i++) rd(nta_pkg::REG_STATUS, s);
    `CHK(s[0], 1'b0)
    `CHK(s[2], ok)
    `CHK(s[7:3], n)
  endtask
  task automatic ans(input logic [3:0] i, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
    logic [31:0] v;
    rd(nta_pkg::REG_RDATA0 | i, v);
    `CHK(v & m, e)
  endtask
  task automatic cfg(input logic [7:0] p, input logic [31:0] e);
    @(posedge ref_clk_i);
    cfg_page_i <= p;
    @(posedge ref_clk_i);
    #1 `CHK(cfg_data_o, e)
  endtask
  task automatic setpg(input logic [7:0] p, input logic [31:0] d);
    wr(nta_pkg::REG_PAGE, {24'h0, p});
    wr(nta_pkg::REG_WDATA, d);
  endtask
  task automatic go_active();
    op(nta_pkg::RQ_WAKE, 1'b1, 5'd2);
    op(nta_pkg::RQ_ANTICOL1, 1'b1, 5'd5);
    op(nta_pkg::RQ_SELECT1, 1'b1, 5'd1);
    op(nta_pkg::RQ_ANTICOL2, 1'b1, 5'd5);
    // level 2 SAK is 00, the NAK code, so reader ok stays low
    op(nta_pkg::RQ_SELECT2, 1'b0, 5'd1);
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    `CHK(state_o, nta_pkg::st_idle)
    `CHK(unlocked_o, 1'b0)
    cfg(8'h04, 32'h0);
  endtask
  // frames other than a wake request are dropped while idle
  task automatic t_idle();
    op(nta_pkg::RQ_READ, 1'b0, 5'd0);
    op(nta_pkg::RQ_ANTICOL1, 1'b0, 5'd0);
    `CHK(state_o, nta_pkg::st_idle)
  endtask
  task automatic t_resolve();
    op(nta_pkg::RQ_WAKE, 1'b1, 5'd2);
    ans(4'h0, {16'h0, nta_pkg::ATQA}, 32'hffff);
    `CHK(state_o, nta_pkg::st_ready1)
    // wrong cascade level must not advance, tag falls silent and idles
    op(nta_pkg::RQ_ANTICOL2, 1'b0, 5'd0);
    `CHK(state_o, nta_pkg::st_idle)
    op(nta_pkg::RQ_WAKE, 1'b1, 5'd2);
    op(nta_pkg::RQ_ANTICOL1, 1'b1, 5'd5);
    ans(4'h0, {UID[23:0], nta_pkg::CASCADE_TAG});
    ans(4'h1, {24'h0, 8'h88 ^ UID[7:0] ^ UID[15:8] ^ UID[23:16]},
      32'hff);
    op(nta_pkg::RQ_SELECT1, 1'b1, 5'd1);
    ans(4'h0, {24'h0, nta_pkg::SAK_CL1}, 32'hff);
    `CHK(state_o, nta_pkg::st_ready2)
    op(nta_pkg::RQ_ANTICOL2, 1'b1, 5'd5);
    ans(4'h0, UID[55:24]);
    ans(4'h1, {24'h0, UID[31:24] ^ UID[39:32] ^ UID[47:40] ^
      UID[55:48]}, 32'hff);
    op(nta_pkg::RQ_SELECT2, 1'b0, 5'd1);
    ans(4'h0, {24'h0, nta_pkg::SAK_CL2}, 32'hff);
    `CHK(state_o, nta_pkg::st_active)
  endtask
  task automatic t_rw();
    setpg(8'h03, 32'h44332211);
    op(nta_pkg::RQ_WRITE, 1'b1, 5'd1);
    setpg(8'h04, 32'h88776655);
    op(nta_pkg::RQ_WRITE, 1'b1, 5'd1);
    cfg(8'h03, 32'h44332211);
    wr(nta_pkg::REG_PAGE, 32'h3);
    op(nta_pkg::RQ_READ, 1'b1, 5'd16);
    ans(4'h0, 32'h44332211);
    ans(4'h1, 32'h88776655);
    ans(4'h2, 32'h0);
  endtask
  // protected pages refused while locked, memory untouched
  task automatic t_locked();
    setpg(nta_pkg::FIRST_PROT_PAGE, PD);
    op(nta_pkg::RQ_WRITE, 1'b0, 5'd1);
    cfg(nta_pkg::FIRST_PROT_PAGE, 32'h0);
    wr(nta_pkg::REG_PAGE, 32'h0d);
    op(nta_pkg::RQ_READ, 1'b0, 5'd1);
    `CHK(state_o, nta_pkg::st_active)
  endtask
  task automatic t_auth();
    wr(nta_pkg::REG_PWD, PW0 ^ 32'h1);
    op(nta_pkg::RQ_AUTH, 1'b0, 5'd1);
    `CHK(state_o, nta_pkg::st_idle)
    `CHK(unlocked_o, 1'b0)
    go_active();
    wr(nta_pkg::REG_PWD, PW0);
    op(nta_pkg::RQ_AUTH, 1'b1, 5'd2);
    ans(4'h0, {16'h0, PK}, 32'hffff);
    `CHK(unlocked_o, 1'b1)
    setpg(nta_pkg::FIRST_PROT_PAGE, PD);
    op(nta_pkg::RQ_WRITE, 1'b1, 5'd1);
    cfg(nta_pkg::FIRST_PROT_PAGE, PD);
    wr(nta_pkg::REG_PAGE, 32'h0d);
    op(nta_pkg::RQ_READ, 1'b1, 5'd16);
    ans(4'h1, PD);
    setpg(nta_pkg::PWD_PAGE, PW1);
    op(nta_pkg::RQ_WRITE, 1'b1, 5'd1);
    wr(nta_pkg::REG_PAGE, 32'he3);
    op(nta_pkg::RQ_READ, 1'b1, 5'd16);
    ans(4'h2, 32'h0);
    cfg(nta_pkg::PWD_PAGE, 32'h0);
    // old password no longer opens, the new one does
    wr(nta_pkg::REG_PWD, PW0);
    op(nta_pkg::RQ_AUTH, 1'b0, 5'd1);
    go_active();
    wr(nta_pkg::REG_PWD, PW1);
    op(nta_pkg::RQ_AUTH, 1'b1, 5'd2);
    `CHK(state_o, nta_pkg::st_unlocked_protected_state)
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cfg_page_i = 8'h00;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_idle();
    t_resolve();
    t_rw();
    t_locked();
    t_auth();
    print_verdict();
  end
endmodule
`default_nettype wire
